// [inc/amd_pkg.sv]
package amd_pkg;

    // Addressing forms resolved by the decoder
    typedef enum logic [3:0] {
        AMD_FORM_OTHER,
        AMD_FORM_DST_DIR,
        AMD_FORM_DST_IDX,
        AMD_FORM_DIR_IMM,
        AMD_FORM_IDX_IMM,
        AMD_FORM_MEM_MEM,
        AMD_FORM_IND_LD,
        AMD_FORM_IND_ST,
        AMD_FORM_FLAG_LOGIC,
        AMD_FORM_CMP
    } amd_form_t;

    // Operation class, decides the flag effect
    typedef enum logic [2:0] {
        AMD_OP_NONE,
        AMD_OP_ARITH,
        AMD_OP_LOGIC,
        AMD_OP_MOVE,
        AMD_OP_CMP,
        AMD_OP_TEST
    } amd_op_t;

    localparam logic [7:0] AMD_OPC_MOV_MEM_MEM = 8'h5F;
    localparam logic [7:0] AMD_OPC_IND_LD      = 8'h3E;
    localparam logic [7:0] AMD_OPC_IND_ST      = 8'h3F;
    localparam logic [7:0] AMD_OPC_AND_F       = 8'h70;
    localparam logic [7:0] AMD_OPC_XOR_F       = 8'h72;
    localparam logic [7:0] AMD_OPC_CMP_FIRST   = 8'h39;
    localparam logic [7:0] AMD_OPC_CMP_LAST    = 8'h3D;
    localparam logic [7:0] AMD_OPC_RMW_FIRST   = 8'h41;
    localparam logic [7:0] AMD_OPC_RMW_LAST    = 8'h46;

    localparam logic [3:0] AMD_CYC_MEM_MEM     = 4'hA;
    localparam logic [3:0] AMD_CYC_IND         = 4'hA;
    localparam logic [3:0] AMD_CYC_FLAG_LOGIC  = 4'h4;
    localparam logic [3:0] AMD_CYC_RMW_DIR     = 4'h9;
    localparam logic [3:0] AMD_CYC_RMW_IDX     = 4'hA;
    localparam logic [3:0] AMD_CYC_CMP_IMM     = 4'h5;
    localparam logic [3:0] AMD_CYC_CMP_DIR     = 4'h7;
    localparam logic [3:0] AMD_CYC_CMP_IDX     = 4'h8;
    localparam logic [3:0] AMD_CYC_CMP_DIMM    = 4'h8;
    localparam logic [3:0] AMD_CYC_CMP_XIMM    = 4'h9;
    localparam logic [3:0] AMD_CYC_DST_DIR     = 4'h7;
    localparam logic [3:0] AMD_CYC_DST_IDX     = 4'h8;
    localparam logic [3:0] AMD_CYC_DIR_IMM     = 4'h9;
    localparam logic [3:0] AMD_CYC_IDX_IMM     = 4'hA;
    localparam logic [3:0] AMD_CYC_DEFAULT     = 4'h4;

    localparam logic [1:0] AMD_LEN_ONE         = 2'h1;
    localparam logic [1:0] AMD_LEN_TWO         = 2'h2;
    localparam logic [1:0] AMD_LEN_THREE       = 2'h3;

    localparam logic [7:0] AMD_X_RESET         = 8'h00;
    localparam logic [7:0] AMD_A_RESET         = 8'h00;
    localparam logic       AMD_Z_RESET         = 1'h1;
    localparam logic       AMD_C_RESET         = 1'h0;

endpackage

// [rtl/amd_addr_calc.sv]
`timescale 1ns/100ps
// Effective address register: direct or operand plus index, wraps in 8 bits
module amd_addr_calc (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       load,
    input  wire logic       use_index,
    input  wire logic [7:0] operand,
    input  wire logic [7:0] index,
    output logic      [7:0] addr
);

    // Sum wraps modulo 256, the index space is one page
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr <= 8'h00;
        end else if (load) begin
            addr <= use_index ? 8'(operand + index) : operand;
        end
    end

endmodule // amd_addr_calc

// [rtl/amd_decoder.sv]
`timescale 1ns/100ps
// Function
// - Destination-indexed adds X to operand 1, takes A as source, 2 bytes.
// - Direct destination with immediate source writes to operand 1, 3 bytes.
// - Indexed destination with immediate adds X to operand 1, 3 bytes.
// - Memory-to-memory form exists only for the move 5F, 3 bytes, 10 cycles.
// - Indirect load reads a pointer, loads A through it, bumps the pointer.
// - Indirect store writes A through the pointer, then bumps the pointer.
// - Indirect load is 3E and store 3F, 10 cycles each, only load sets Z.
// - Add, add-with-carry, subtract and borrow-subtract update C and Z.
// - AND, OR and XOR on A or memory update only Z.
// - Logic ops on the flag register take 4 cycles, 2 bytes, touch C and Z.
// - Compare sets Z on equal and C on less-than, storing no result.
// - Register-space logic with immediate mask is 3 bytes, 9 cycles direct or 10 indexed, Z.
module amd_decoder (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       instr_valid,
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] operand1,
    input  wire logic [7:0] operand2,
    input  wire logic [7:0] index_x,
    input  wire logic [7:0] acc_in,
    input  wire logic [7:0] mem_rdata,
    output logic            dec_valid,
    output amd_pkg::amd_form_t form,
    output amd_pkg::amd_op_t   op_class,
    output logic      [1:0] instr_len,
    output logic      [3:0] cycles,
    output logic            upd_carry,
    output logic            upd_zero,
    output logic            acc_write,
    output logic            result_store,
    output logic            imm_source,
    output logic      [7:0] imm_value,
    output logic      [7:0] dest_addr,
    output logic      [7:0] ptr_next,
    output logic            cmp_zero,
    output logic            cmp_carry
);

    amd_pkg::amd_form_t form_nxt;
    amd_pkg::amd_op_t   op_nxt;
    logic [1:0] len_nxt;
    logic [3:0] cyc_nxt;
    logic       use_idx;
    logic       upc_nxt;
    logic       upz_nxt;
    logic       accw_nxt;
    logic       store_nxt;
    logic       imm_nxt;

    // Checks share one clock and stay quiet while reset is held
    default clocking dec_cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // Column-wise operation class of the low opcode range
    function automatic amd_pkg::amd_op_t op_of(input logic [7:0] opc);
        amd_pkg::amd_op_t r;
        r = amd_pkg::AMD_OP_NONE;
        if (opc < 8'h20 && opc[2:0] >= 3'h1 && opc[2:0] <= 3'h7 &&
            opc != 8'h10 && opc != 8'h18) begin
            r = amd_pkg::AMD_OP_ARITH;
        end else if (opc >= 8'h21 && opc <= 8'h37 && opc[2:0] != 3'h0) begin
            r = amd_pkg::AMD_OP_LOGIC;
        end else if (opc >= amd_pkg::AMD_OPC_RMW_FIRST &&
                     opc <= amd_pkg::AMD_OPC_RMW_LAST) begin
            r = amd_pkg::AMD_OP_LOGIC;
        end else if (opc >= amd_pkg::AMD_OPC_CMP_FIRST &&
                     opc <= amd_pkg::AMD_OPC_CMP_LAST) begin
            r = amd_pkg::AMD_OP_CMP;
        end else if (opc >= 8'h50 && opc <= 8'h63) begin
            r = amd_pkg::AMD_OP_MOVE;
        end else if (opc == amd_pkg::AMD_OPC_IND_LD ||
                     opc == amd_pkg::AMD_OPC_IND_ST) begin
            r = amd_pkg::AMD_OP_MOVE;
        end else if (opc >= amd_pkg::AMD_OPC_AND_F &&
                     opc <= amd_pkg::AMD_OPC_XOR_F) begin
            r = amd_pkg::AMD_OP_LOGIC;
        end
        return r;
    endfunction

    // Form, length and cycle count from the opcode
    always_comb begin
        form_nxt  = amd_pkg::AMD_FORM_OTHER;
        op_nxt    = op_of(opcode);
        len_nxt   = amd_pkg::AMD_LEN_ONE;
        cyc_nxt   = amd_pkg::AMD_CYC_DEFAULT;
        use_idx   = 1'b0;
        store_nxt = 1'b0;
        imm_nxt   = 1'b0;
        accw_nxt  = 1'b0;
        if (opcode == amd_pkg::AMD_OPC_MOV_MEM_MEM) begin
            form_nxt  = amd_pkg::AMD_FORM_MEM_MEM;
            len_nxt   = amd_pkg::AMD_LEN_THREE;
            cyc_nxt   = amd_pkg::AMD_CYC_MEM_MEM;
            store_nxt = 1'b1;
        end else if (opcode == amd_pkg::AMD_OPC_IND_LD) begin
            form_nxt  = amd_pkg::AMD_FORM_IND_LD;
            len_nxt   = amd_pkg::AMD_LEN_TWO;
            cyc_nxt   = amd_pkg::AMD_CYC_IND;
            accw_nxt  = 1'b1;
        end else if (opcode == amd_pkg::AMD_OPC_IND_ST) begin
            form_nxt  = amd_pkg::AMD_FORM_IND_ST;
            len_nxt   = amd_pkg::AMD_LEN_TWO;
            cyc_nxt   = amd_pkg::AMD_CYC_IND;
            store_nxt = 1'b1;
        end else if (opcode >= amd_pkg::AMD_OPC_AND_F &&
                     opcode <= amd_pkg::AMD_OPC_XOR_F) begin
            form_nxt  = amd_pkg::AMD_FORM_FLAG_LOGIC;
            len_nxt   = amd_pkg::AMD_LEN_TWO;
            cyc_nxt   = amd_pkg::AMD_CYC_FLAG_LOGIC;
        end else if (op_nxt == amd_pkg::AMD_OP_CMP) begin
            form_nxt  = amd_pkg::AMD_FORM_CMP;
            // Codes 39..3D: imm, direct, indexed, then two 3-byte forms
            len_nxt   = opcode[2] ? amd_pkg::AMD_LEN_THREE
                                  : amd_pkg::AMD_LEN_TWO;
            imm_nxt   = (opcode[2:1] != 2'h1);
            use_idx   = opcode[0] && (opcode[2:0] != 3'h1);
            case (opcode[2:0])
                3'h1:    cyc_nxt = amd_pkg::AMD_CYC_CMP_IMM;
                3'h2:    cyc_nxt = amd_pkg::AMD_CYC_CMP_DIR;
                3'h3:    cyc_nxt = amd_pkg::AMD_CYC_CMP_IDX;
                3'h4:    cyc_nxt = amd_pkg::AMD_CYC_CMP_DIMM;
                default: cyc_nxt = amd_pkg::AMD_CYC_CMP_XIMM;
            endcase
        end else if (opcode >= amd_pkg::AMD_OPC_RMW_FIRST &&
                     opcode <= amd_pkg::AMD_OPC_RMW_LAST) begin
            // Odd opcodes are the direct register-space forms
            form_nxt  = opcode[0] ? amd_pkg::AMD_FORM_DIR_IMM
                                  : amd_pkg::AMD_FORM_IDX_IMM;
            len_nxt   = amd_pkg::AMD_LEN_THREE;
            cyc_nxt   = opcode[0] ? amd_pkg::AMD_CYC_RMW_DIR
                                  : amd_pkg::AMD_CYC_RMW_IDX;
            use_idx   = ~opcode[0];
            store_nxt = 1'b1;
            imm_nxt   = 1'b1;
        end else if (op_nxt == amd_pkg::AMD_OP_ARITH ||
                     (op_nxt == amd_pkg::AMD_OP_LOGIC && opcode < 8'h38)) begin
            // Codes x4..x7 write memory, x1..x3 are source forms into A
            store_nxt = opcode[2];
            accw_nxt  = ~opcode[2];
            imm_nxt   = (opcode[2:1] == 2'h3);
            use_idx   = opcode[0] && (opcode[2:0] != 3'h1);
            len_nxt   = imm_nxt ? amd_pkg::AMD_LEN_THREE
                                : amd_pkg::AMD_LEN_TWO;
            case (opcode[2:0])
                3'h4:    form_nxt = amd_pkg::AMD_FORM_DST_DIR;
                3'h5:    form_nxt = amd_pkg::AMD_FORM_DST_IDX;
                3'h6:    form_nxt = amd_pkg::AMD_FORM_DIR_IMM;
                3'h7:    form_nxt = amd_pkg::AMD_FORM_IDX_IMM;
                default: form_nxt = amd_pkg::AMD_FORM_OTHER;
            endcase
            case (opcode[2:0])
                3'h4:    cyc_nxt = amd_pkg::AMD_CYC_DST_DIR;
                3'h5:    cyc_nxt = amd_pkg::AMD_CYC_DST_IDX;
                3'h6:    cyc_nxt = amd_pkg::AMD_CYC_DIR_IMM;
                3'h7:    cyc_nxt = amd_pkg::AMD_CYC_IDX_IMM;
                default: cyc_nxt = amd_pkg::AMD_CYC_DEFAULT;
            endcase
        end
    end

    // Flag effect by operation class
    always_comb begin
        upc_nxt = 1'b0;
        upz_nxt = 1'b0;
        case (op_nxt)
            amd_pkg::AMD_OP_ARITH: begin
                upc_nxt = 1'b1;
                upz_nxt = 1'b1;
            end
            amd_pkg::AMD_OP_LOGIC: begin
                upc_nxt = (form_nxt == amd_pkg::AMD_FORM_FLAG_LOGIC);
                upz_nxt = 1'b1;
            end
            amd_pkg::AMD_OP_CMP: begin
                upc_nxt = 1'b1;
                upz_nxt = 1'b1;
            end
            amd_pkg::AMD_OP_MOVE: begin
                upz_nxt = (opcode == amd_pkg::AMD_OPC_IND_LD);
            end
            default: begin
                upc_nxt = 1'b0;
            end
        endcase
    end

    // Effective destination address, indexed or direct
    amd_addr_calc u_addr (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .load      (instr_valid),
        .use_index (use_idx),
        .operand   (operand1),
        .index     (index_x),
        .addr      (dest_addr)
    );

    // Registered decode outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dec_valid    <= 1'b0;
            form         <= amd_pkg::AMD_FORM_OTHER;
            op_class     <= amd_pkg::AMD_OP_NONE;
            instr_len    <= 2'h0;
            cycles       <= 4'h0;
            upd_carry    <= 1'b0;
            upd_zero     <= 1'b0;
            acc_write    <= 1'b0;
            result_store <= 1'b0;
            imm_source   <= 1'b0;
            imm_value    <= 8'h00;
        end else begin
            dec_valid    <= instr_valid;
            if (instr_valid) begin
                form         <= form_nxt;
                op_class     <= op_nxt;
                instr_len    <= len_nxt;
                cycles       <= cyc_nxt;
                upd_carry    <= upc_nxt;
                upd_zero     <= upz_nxt;
                acc_write    <= accw_nxt;
                result_store <= store_nxt && op_nxt != amd_pkg::AMD_OP_CMP;
                imm_source   <= imm_nxt;
                imm_value    <= (len_nxt == amd_pkg::AMD_LEN_THREE)
                                ? operand2 : operand1;
            end
        end
    end

    // Pointer bump and compare outcome, using memory read data
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ptr_next  <= 8'h00;
            cmp_zero  <= 1'b0;
            cmp_carry <= 1'b0;
        end else if (instr_valid) begin
            ptr_next  <= 8'(mem_rdata + 8'h01);
            cmp_zero  <= (acc_in == mem_rdata);
            cmp_carry <= (acc_in < mem_rdata);
        end
    end

    chk_ind_timing: assert property (instr_valid &&
        (opcode == 8'h3E || opcode == 8'h3F) |=>
        cycles == 4'hA && instr_len == 2'h2)
        else $error("indirect form timing wrong");
    chk_memmem_len: assert property (instr_valid && opcode == 8'h5F |=>
        cycles == 4'hA && instr_len == 2'h3 &&
        form == amd_pkg::AMD_FORM_MEM_MEM)
        else $error("memory move decode wrong");
    chk_store_noz: assert property (instr_valid && opcode == 8'h3F |=>
        !upd_zero && !acc_write)
        else $error("indirect store touched flags");
    chk_arith_flags: assert property (instr_valid &&
        opcode >= 8'h01 && opcode <= 8'h07 |=> upd_carry && upd_zero)
        else $error("arith flags not updated");
    chk_logic_carry: assert property (instr_valid &&
        opcode >= 8'h21 && opcode <= 8'h27 |=> !upd_carry && upd_zero)
        else $error("logic op changed carry");
    chk_flag_logic: assert property (instr_valid && opcode == 8'h70 |=>
        cycles == 4'h4 && instr_len == 2'h2 && upd_carry && upd_zero)
        else $error("flag logic decode wrong");
    chk_cmp_nostore: assert property (instr_valid &&
        opcode == 8'h3A |=> !result_store && cycles == 4'h7 &&
        cmp_zero == ($past(acc_in) == $past(mem_rdata)))
        else $error("compare decode wrong");
    chk_rmw_direct: assert property (instr_valid && opcode == 8'h41 |=>
        cycles == 4'h9 && instr_len == 2'h3 && upd_zero)
        else $error("register logic decode wrong");
    chk_idx_addr: assert property (instr_valid &&
        opcode == 8'h05 |=> !acc_write &&
        dest_addr == 8'($past(operand1) + $past(index_x)))
        else $error("indexed address wrong");
    chk_dirimm: assert property (instr_valid && opcode == 8'h06 |=>
        dest_addr == $past(operand1) && imm_value == $past(operand2) &&
        instr_len == 2'h3)
        else $error("direct immediate wrong");
    chk_idximm: assert property (instr_valid && opcode == 8'h07 |=>
        dest_addr == 8'($past(operand1) + $past(index_x)) &&
        imm_value == $past(operand2))
        else $error("indexed immediate wrong");
    chk_ptr_bump: assert property (instr_valid &&
        opcode == 8'h3E |=> acc_write && upd_zero &&
        ptr_next == 8'($past(mem_rdata) + 8'h01))
        else $error("pointer bump wrong");

    cov_ind_load: cover property (@(posedge core_clk)
        instr_valid && opcode == 8'h3E);
    cov_mem_move: cover property (@(posedge core_clk)
        instr_valid && opcode == 8'h5F);
    cov_cmp_less: cover property (@(posedge core_clk)
        instr_valid && opcode == 8'h3A ##1 cmp_carry);

endmodule // amd_decoder

// [verification/test_cpu_addressing_mode_decoder.sv]
`timescale 1ns/100ps
module test_cpu_addressing_mode_decoder;

    // Expected decode of one opcode, masks say which fields to judge
    typedef struct packed {
        amd_pkg::amd_form_t form;
        amd_pkg::amd_op_t   op;
        logic [1:0]         len;
        logic [3:0]         cyc;
        logic               uc, uz, aw, idx, ptr, cmp, st;
        logic               fm, oc, fl, ac, dc;
    } amd_exp_t;

    logic               core_clk, sys_rst, instr_valid;
    logic [7:0]         opcode, operand1, operand2;
    logic [7:0]         index_x, acc_in, mem_rdata;
    logic               dec_valid, upd_carry, upd_zero, acc_write;
    logic               result_store, imm_source, cmp_zero, cmp_carry;
    amd_pkg::amd_form_t form;
    amd_pkg::amd_op_t   op_class;
    logic [1:0]         instr_len;
    logic [3:0]         cycles;
    logic [7:0]         imm_value, dest_addr, ptr_next;
    int                 num_errors, n_checks;
    integer             seed;
    logic [7:0]         codes[$];

    amd_decoder i_dut (.core_clk, .sys_rst, .instr_valid, .opcode,
        .operand1, .operand2, .index_x, .acc_in, .mem_rdata, .dec_valid,
        .form, .op_class, .instr_len, .cycles, .upd_carry, .upd_zero,
        .acc_write, .result_store, .imm_source, .imm_value, .dest_addr,
        .ptr_next, .cmp_zero, .cmp_carry);

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Decode expected from the opcode table, per family
    function automatic amd_exp_t exp_of(input logic [7:0] o);
        amd_exp_t e;
        e = '0;
        e.fm = 1'b1;
        e.fl = 1'b1;
        if (o < 8'h38) begin
            e.op = (o < 8'h20) ? amd_pkg::AMD_OP_ARITH : amd_pkg::AMD_OP_LOGIC;
            e.uc = (o < 8'h20);
            e.uz = 1'b1;
            e.oc = 1'b1;
            e.ac = 1'b1;
            e.dc = 1'b1;
            e.idx = o[0];
            e.st = 1'b1;
            e.len = o[1] ? 2'h3 : 2'h2;
            e.cyc = 4'h7 + {2'h0, o[1:0]};
            case (o[1:0])
                2'h0: e.form = amd_pkg::AMD_FORM_DST_DIR;
                2'h1: e.form = amd_pkg::AMD_FORM_DST_IDX;
                2'h2: e.form = amd_pkg::AMD_FORM_DIR_IMM;
                default: e.form = amd_pkg::AMD_FORM_IDX_IMM;
            endcase
        end else if (o < 8'h3E) begin
            e.form = amd_pkg::AMD_FORM_CMP;
            e.op = amd_pkg::AMD_OP_CMP;
            e.oc = 1'b1;
            e.uc = 1'b1;
            e.uz = 1'b1;
            e.cmp = 1'b1;
            e.len = (o > 8'h3B) ? 2'h3 : 2'h2;
            case (o)
                8'h39: e.cyc = 4'h5;
                8'h3A: e.cyc = 4'h7;
                8'h3B, 8'h3C: e.cyc = 4'h8;
                default: e.cyc = 4'h9;
            endcase
        end else if (o < 8'h40) begin
            e.form = o[0] ? amd_pkg::AMD_FORM_IND_ST
                          : amd_pkg::AMD_FORM_IND_LD;
            e.st = o[0];
            e.op = amd_pkg::AMD_OP_MOVE;
            e.oc = 1'b1;
            e.len = 2'h2;
            e.cyc = 4'hA;
            e.uz = ~o[0];
            e.aw = ~o[0];
            e.ac = 1'b1;
            e.ptr = 1'b1;
        end else if (o < 8'h47) begin
            // Form of register-space logic is left to the designer
            e.fm = 1'b0;
            e.len = 2'h3;
            e.cyc = o[0] ? 4'h9 : 4'hA;
            e.uz = 1'b1;
            e.dc = 1'b1;
            e.idx = ~o[0];
            e.st = 1'b1;
        end else if (o == 8'h5F) begin
            e.form = amd_pkg::AMD_FORM_MEM_MEM;
            e.st = 1'b1;
            e.op = amd_pkg::AMD_OP_MOVE;
            e.oc = 1'b1;
            e.len = 2'h3;
            e.cyc = 4'hA;
            e.dc = 1'b1;
        end else begin
            e.form = amd_pkg::AMD_FORM_FLAG_LOGIC;
            e.len = 2'h2;
            e.cyc = 4'h4;
            e.uc = 1'b1;
            e.uz = 1'b1;
        end
        return e;
    endfunction

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    // Drive one request at the falling edge, judge the answer a cycle on
    task automatic send(input logic [7:0] o, a1, a2, x, a, m);
        amd_exp_t e;
        e = exp_of(o);
        instr_valid = 1'b1;
        opcode = o;
        operand1 = a1;
        operand2 = a2;
        index_x = x;
        acc_in = a;
        mem_rdata = m;
        @(posedge core_clk);
        @(negedge core_clk);
        chk_bit(dec_valid, 1'b1);
        if (e.fm) chk_byte({4'h0, form}, {4'h0, e.form});
        if (e.oc) chk_byte({5'h0, op_class}, {5'h0, e.op});
        chk_byte({6'h0, instr_len}, {6'h0, e.len});
        chk_byte({4'h0, cycles}, {4'h0, e.cyc});
        if (e.fl) chk_bit(upd_carry, e.uc);
        if (e.fl) chk_bit(upd_zero, e.uz);
        if (e.ac) chk_bit(acc_write, e.aw);
        if (e.ac && e.dc) chk_bit(imm_source, e.len == 2'h3);
        if (e.dc) chk_byte(dest_addr, e.idx ? 8'(a1 + x) : a1);
        chk_byte(imm_value, (e.len == 2'h3) ? a2 : a1);
        if (e.ptr) chk_byte(ptr_next, 8'(m + 8'h01));
        if (e.cmp) chk_bit(cmp_zero, a == m);
        if (e.cmp) chk_bit(cmp_carry, a < m);
        chk_bit(result_store, e.st);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog so a stuck run still reaches the verdict
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        $display("[ERR] t=%0t got %0h exp %0h", $time, 1'b0, 1'b1);
        stop_test;
    end

    initial begin
        int k;
        seed = 32'h5411d119;
        {sys_rst, instr_valid} = 2'h2;
        {opcode, operand1, operand2} = 24'h000000;
        {index_x, acc_in, mem_rdata} = 24'h000000;
        num_errors = 0;
        n_checks = 0;
        for (int i = 0; i < 8'h38; i++) if (i % 8 > 3) codes.push_back(8'(i));
        for (int i = 8'h39; i < 8'h47; i++) begin
            if (i != 8'h40) codes.push_back(8'(i));
        end
        codes.push_back(8'h5F);
        for (int i = 8'h70; i < 8'h73; i++) codes.push_back(8'(i));
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        chk_bit(dec_valid, 1'b0);
        chk_byte({4'h0, cycles}, 8'h00);
        $display("reset test done");
        // Every code back to back; address and pointer wrap past FF
        foreach (codes[i]) begin
            send(codes[i], 8'hFF, 8'h5A, 8'h01, 8'h10, 8'hFF);
        end
        for (int i = 8'h39; i < 8'h3E; i++) begin
            send(8'(i), 8'h40, 8'h01, 8'h07, 8'h33, 8'h33);
            send(8'(i), 8'h40, 8'h01, 8'h07, 8'h34, 8'h33);
        end
        $display("directed test done");
        repeat (400) begin
            k = $unsigned($random(seed)) % codes.size();
            send(codes[k], 8'($random(seed)), 8'($random(seed)),
                 8'($random(seed)), 8'($random(seed)),
                 8'($random(seed)));
        end
        $display("random test done");
        send(8'h5F, 8'h12, 8'h34, 8'h00, 8'h00, 8'h00);
        // Idle cycle: pulse must drop, decode must hold
        instr_valid = 1'b0;
        opcode = 8'h3E;
        @(posedge core_clk);
        @(negedge core_clk);
        chk_bit(dec_valid, 1'b0);
        chk_byte({4'h0, cycles}, 8'h0A);
        $display("hold test done");
        // Reset in mid-run with a request pending
        sys_rst = 1'b1;
        instr_valid = 1'b1;
        @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        chk_bit(dec_valid, 1'b0);
        chk_byte({6'h0, instr_len}, 8'h00);
        send(8'h3E, 8'h08, 8'h00, 8'h00, 8'h00, 8'h20);
        instr_valid = 1'b0;
        $display("mid reset test done");
        stop_test;
    end

endmodule // test_cpu_addressing_mode_decoder
